/* File: mmsp_pkg.sv */
/*
 Shared constants and carrier types of the module management serial port.
 Assumes a 100 ns system clock and a 12-bit APB byte address.
*/
package mmsp_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int TX_OFF_MAX_NS = 10000;
	// Longest time, so round down
	localparam int TX_OFF_CYCLES = TX_OFF_MAX_NS / CLK_PERIOD_NS;
	localparam int SYNC_LATENCY  = 3;

	// ----------------------------------------
	// Serial addresses and memory layout
	// ----------------------------------------
	localparam logic [6:0] DEV_ID    = 7'h50;
	localparam logic [6:0] DEV_DIAG  = 7'h51;
	localparam int         MAP_BYTES = 256;
	localparam int         MEM_WORDS = 2 * MAP_BYTES;
	localparam int         NUM_MON   = 5;
	localparam int         MON_W     = 16;
	localparam int         THR_BASE  = 0;
	localparam int         THR_STEP  = 8;
	localparam int         CAL_BASE  = 80;
	localparam logic [3:0] LIVE_HI   = 4'h6;
	localparam logic [4:0] FLAG_HI   = 5'h0e;
	localparam logic [7:0] USER_BASE = 8'h80;
	localparam int         STAT_SLOT = 14;
	localparam int         ALM_SLOT  = 0;
	localparam int         WRN_SLOT  = 4;

	// ----------------------------------------
	// APB register map
	// ----------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam int          MEM_WIN    = 11;
	localparam int          CTRL_EXT   = 0;
	localparam int          CTRL_SOFT  = 1;
	localparam logic [1:0]  CTRL_RESET = 2'h0;
	localparam int          STS_TXOFF  = 0;
	localparam int          STS_FAULT  = 1;
	localparam int          STS_LOST   = 2;
	localparam int          STS_BUSY   = 3;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic       valid;
		logic       map;
		logic [7:0] addr;
		logic [7:0] data;
	} ser_wr_t;

	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] vcc;
		logic [15:0] bias;
		logic [15:0] txpwr;
		logic [15:0] rxpwr;
	} mon_t;

endpackage

/* File: serial_id_target.sv */
/*
 Two-wire serial target: start/stop detection, address match, byte
 transfer with pointer auto-advance. Assumes the host drives the clock
 and that pins reach it unsynchronised.
*/
`timescale 1ns/1ps
module serial_id_target #(
	parameter logic [6:0] ID_ADDR   = mmsp_pkg::DEV_ID,
	parameter logic [6:0] DIAG_ADDR = mmsp_pkg::DEV_DIAG
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// Two-wire pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_oe,
	// Memory side
	output logic [7:0]       ptr,
	output logic             map_sel,
	input  wire logic [7:0]  rd_byte,
	output mmsp_pkg::ser_wr_t wr,
	output logic             busy
);

	if (ID_ADDR == DIAG_ADDR) begin : g_bad
		$error("Both maps need distinct addresses");
	end

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
		ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK, ST_RD_NEXT
	} ser_state_t;

	ser_state_t state;
	logic [2:0] cnt;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic       ack_drv;
	logic       rw;
	logic       scl_s1, scl_s2, scl_d;
	logic       sda_s1, sda_s2, sda_d;

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	// Clock is only ever sampled, never driven
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{scl_s1, scl_s2, scl_d} <= 3'h7;
			{sda_s1, sda_s2, sda_d} <= 3'h7;
		end else if (ce) begin
			{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
		end
	end

	wire logic       scl_rise = scl_s2 & ~scl_d;
	wire logic       scl_fall = ~scl_s2 & scl_d;
	wire logic       scl_high = scl_s2 & scl_d;
	wire logic       start_c  = scl_high & sda_d & ~sda_s2;
	wire logic       stop_c   = scl_high & ~sda_d & sda_s2;
	wire logic [7:0] byte_in  = {shreg[6:0], sda_s2};
	wire logic       id_hit   = byte_in[7:1] == ID_ADDR;
	wire logic       diag_hit = byte_in[7:1] == DIAG_ADDR;
	wire logic       addr_hit = id_hit | diag_hit;
	wire logic       last_bit = cnt == 3'h7;
	wire logic       ack_addr = state == ST_ACK_ADDR;

	assign busy = state != ST_IDLE;

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state   <= ST_IDLE;
			cnt     <= 3'h0;
			shreg   <= 8'h00;
			txreg   <= 8'h00;
			sda_oe  <= 1'b0;
			ack_drv <= 1'b0;
			rw      <= 1'b0;
			map_sel <= 1'b0;
			ptr     <= 8'h00;
			wr      <= '0;
		end else if (ce) begin
			wr.valid <= 1'b0;
			if (start_c) begin
				state   <= ST_ADDR;
				cnt     <= 3'h0;
				sda_oe  <= 1'b0;
				ack_drv <= 1'b0;
			end else if (stop_c) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_REG, ST_WR: begin
						shreg <= byte_in;
						cnt   <= cnt + 3'h1;
						if (last_bit && state == ST_ADDR) begin
							state <= addr_hit ? ST_ACK_ADDR : ST_IDLE;
							rw    <= byte_in[0];
							if (addr_hit)
								map_sel <= diag_hit;
						end else if (last_bit && state == ST_REG) begin
							ptr   <= byte_in;
							state <= ST_ACK_REG;
						end else if (last_bit) begin
							wr    <= '{1'b1, map_sel, ptr, byte_in};
							ptr   <= ptr + 8'h01;
							state <= ST_ACK_WR;
						end
					end
					ST_RD_ACK:
						state <= sda_s2 ? ST_IDLE : ST_RD_NEXT;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WR: begin
						ack_drv <= ~ack_drv;
						// Write acknowledge does not depend on protection
						if (!ack_drv) begin
							sda_oe <= 1'b1;
						end else if (ack_addr && rw) begin
							sda_oe <= ~rd_byte[7];
							txreg  <= {rd_byte[6:0], 1'b0};
							cnt    <= 3'h1;
							state  <= ST_RD;
						end else begin
							sda_oe <= 1'b0;
							cnt    <= 3'h0;
							state  <= ack_addr ? ST_REG : ST_WR;
						end
					end
					ST_RD_NEXT: begin
						sda_oe <= ~rd_byte[7];
						txreg  <= {rd_byte[6:0], 1'b0};
						cnt    <= 3'h1;
						state  <= ST_RD;
					end
					ST_RD: begin
						if (cnt == 3'h0) begin
							sda_oe <= 1'b0;
							ptr    <= ptr + 8'h01;
							state  <= ST_RD_ACK;
						end else begin
							sda_oe <= ~txreg[7];
							txreg  <= {txreg[6:0], 1'b0};
							cnt    <= cnt + 3'h1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_drive_on_fall: assert property (
		@(posedge clk) disable iff (!rst_b)
		$changed(sda_oe) |-> $past(scl_fall) || $past(start_c) || $past(stop_c))
		else $error("Data line changed away from a clock fall");

	a_capture_rise: assert property (
		@(posedge clk) disable iff (!rst_b)
		wr.valid |-> $past(scl_rise) && $past(state) == ST_WR)
		else $error("Write not taken on a clock rise");

	a_start_detect: assert property (
		@(posedge clk) disable iff (!rst_b)
		ce && start_c |=> state == ST_ADDR && !sda_oe)
		else $error("Start condition missed");

	a_auto_advance: assert property (
		@(posedge clk) disable iff (!rst_b)
		wr.valid |-> ptr == wr.addr + 8'h01)
		else $error("Pointer did not advance after a write");

	a_addr_match: assert property (
		@(posedge clk) disable iff (!rst_b)
		state == ST_ACK_ADDR && $past(state) == ST_ADDR |-> $past(addr_hit))
		else $error("Acknowledged a foreign address");

	c_serial_read: cover property (
		@(posedge clk) disable iff (!rst_b) state == ST_RD_ACK ##[1:200] state == ST_RD);

endmodule

/* File: module_mgmt_serial_port.sv */
/*
 Management side of a pluggable transceiver: two 256-byte maps on a
 two-wire link, diagnostics with alarm and warning flags, and the
 status and control pins. Software loads the maps over APB.
 Assumes monitor values arrive from logic on CLOCK and that pins are
 asynchronous to CLOCK.
*/
// The address map and the APB interface to the registers are this design's own decisions.
//
// Function
// - Identification map of 256 bytes answers at serial address A0h.
// - Diagnostic map answers at A2h; identification map stays as it is.
// - Bits taken on clock rise; writes stored only where not protected.
// - Returned data bits change on clock fall.
// - Data line is two-way; start and stop conditions are recognised.
// - Bytes reached singly or sequentially with pointer auto-advance.
// - Loss-of-signal low while receiving, high when no signal.
// - Transmitter off within 10 us of transmit disable.
// - Temperature, bias, transmit, receive power, supply readable live.
// - Alarm and warning flags set when a value leaves its range.
// - Reported values internally calibrated unless set otherwise.
// - Identification map holds readable capability and maker data.
// - Presence pin held at ground.
// - Transmitter disabled while disable input high; pulled up if open.
// - Transmit fault high on laser fault, low otherwise.
//
`timescale 1ns/1ps
module module_mgmt_serial_port #(
	parameter int TX_OFF_LIMIT = mmsp_pkg::TX_OFF_CYCLES
) (
	// Clock, reset, enable
	input  wire logic           CLOCK,
	input  wire logic           RST_B,
	input  wire logic           CLK_EN,
	// APB slave
	input  wire logic           PSEL,
	input  wire logic           PENABLE,
	input  wire logic           PWRITE,
	input  wire logic [11:0]    PADDR,
	input  wire logic [31:0]    PWDATA,
	output logic [31:0]         PRDATA,
	output logic                PREADY,
	output logic                PSLVERR,
	// Two-wire management bus
	input  wire logic           SCL_IN,
	input  wire logic           SDA_IN,
	output logic                SDA_OUT,
	output logic                SDA_OE,
	// Module pins
	input  wire logic           TX_DISABLE,
	input  wire logic           RX_SIGNAL_DETECT,
	input  wire logic           LASER_FAULT,
	input  wire mmsp_pkg::mon_t MON,
	output logic                TX_OFF,
	output logic                RX_SIGNAL_LOST,
	output logic                TX_FAULT,
	output logic                PRESENCE_PIN
);

	if (TX_OFF_LIMIT < mmsp_pkg::SYNC_LATENCY) begin : g_bad
		$error("Transmit shut-off limit below pin latency");
	end

	localparam int   DIAG  = mmsp_pkg::MAP_BYTES;
	localparam int   TxLim = TX_OFF_LIMIT;

	logic [7:0]      mem [mmsp_pkg::MEM_WORDS];
	logic [1:0]      ctrl;
	logic [2:0]      pin_s1, pin_s2;
	logic [7:0]      ser_ptr;
	logic            ser_map;
	logic            ser_busy;
	mmsp_pkg::ser_wr_t ser_wr;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire logic       setup    = PSEL & ~PENABLE;
	wire logic       access   = PSEL & PENABLE;
	wire logic       aligned  = PADDR[1:0] == 2'h0;
	wire logic       mem_hit  = aligned & PADDR[mmsp_pkg::MEM_WIN];
	wire logic       ctrl_hit = PADDR == mmsp_pkg::REG_CTRL;
	wire logic       stat_hit = PADDR == mmsp_pkg::REG_STATUS;
	wire logic       addr_ok  = mem_hit | ctrl_hit | stat_hit;
	wire logic [8:0] apb_idx  = PADDR[10:2];
	wire logic       apb_we   = access & PWRITE & mem_hit;
	wire logic       ctrl_we  = access & PWRITE & ctrl_hit;
	wire logic       ext_cal  = ctrl[mmsp_pkg::CTRL_EXT];
	wire logic       soft_dis = ctrl[mmsp_pkg::CTRL_SOFT];

	assign PREADY  = 1'b1;
	assign PSLVERR = access & ~addr_ok;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			ctrl <= mmsp_pkg::CTRL_RESET;
		else if (CLK_EN && ctrl_we)
			ctrl <= PWDATA[1:0];
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire logic [2:0] pin_in = {TX_DISABLE, RX_SIGNAL_DETECT, LASER_FAULT};

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1 <= 3'h4;
			pin_s2 <= 3'h4;
		end else if (CLK_EN) begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
		end
	end

	wire logic tx_dis_s = pin_s2[2];
	wire logic rx_det_s = pin_s2[1];
	wire logic fault_s  = pin_s2[0];

	// ----------------------------------------
	// Module pins
	// ----------------------------------------
	// An open disable pin reads high through the pad pull-up, so reset
	// leaves the laser off until the host lowers it.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			TX_OFF         <= 1'b1;
			RX_SIGNAL_LOST <= 1'b1;
			TX_FAULT       <= 1'b0;
		end else if (CLK_EN) begin
			TX_OFF         <= tx_dis_s | soft_dis;
			RX_SIGNAL_LOST <= ~rx_det_s;
			TX_FAULT       <= fault_s;
		end
	end

	assign PRESENCE_PIN = 1'b0;
	assign SDA_OUT      = 1'b0;

	// ----------------------------------------
	// Serial target
	// ----------------------------------------
	logic [7:0] ser_view;

	serial_id_target u_target (
		.clk     (CLOCK),
		.rst_b   (RST_B),
		.ce      (CLK_EN),
		.scl_in  (SCL_IN),
		.sda_in  (SDA_IN),
		.sda_oe  (SDA_OE),
		.ptr     (ser_ptr),
		.map_sel (ser_map),
		.rd_byte (ser_view),
		.wr      (ser_wr),
		.busy    (ser_busy)
	);

	wire logic [8:0] ser_idx   = {ser_wr.map, ser_wr.addr};
	wire logic       ser_allow = ser_wr.map && ser_wr.addr >= mmsp_pkg::USER_BASE;
	wire logic       ser_we    = ser_wr.valid & ser_allow;

	// ----------------------------------------
	// Map storage
	// ----------------------------------------
	// Flops stand in for non-volatile storage: content is lost at reset
	// and software must reload the identification data.
	for (genvar i = 0; i < mmsp_pkg::MEM_WORDS; i++) begin : g_mem
		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B)
				mem[i] <= 8'h00;
			else if (CLK_EN && apb_we && apb_idx == 9'(i))
				mem[i] <= PWDATA[7:0];
			else if (CLK_EN && ser_we && ser_idx == 9'(i))
				mem[i] <= ser_wr.data;
		end
	end

	// ----------------------------------------
	// Diagnostics
	// ----------------------------------------
	wire logic [79:0] mon_vec = MON;
	wire logic [7:0]  live_b [16];
	wire logic [7:0]  flag_b [8];
	wire logic [9:0]  alarm_v;
	wire logic [9:0]  warn_v;

	for (genvar p = 0; p < mmsp_pkg::NUM_MON; p++) begin : g_mon
		localparam int TB = DIAG + mmsp_pkg::THR_BASE + mmsp_pkg::THR_STEP * p;
		localparam int CB = DIAG + mmsp_pkg::CAL_BASE + 2 * p;
		logic [15:0] raw, ofs, cal;
		logic [15:0] thr [4];
		logic [3:0]  flg;

		assign raw = mon_vec[79 - 16 * p -: 16];
		assign ofs = {mem[CB], mem[CB + 1]};
		assign cal = ext_cal ? raw : 16'(raw + ofs);

		for (genvar k = 0; k < 4; k++) begin : g_thr
			assign thr[k] = {mem[TB + 2 * k], mem[TB + 2 * k + 1]};
		end

		// Order per value: high alarm, low alarm, high warning, low warning
		always_ff @(posedge CLOCK or negedge RST_B) begin
			if (!RST_B)
				flg <= 4'h0;
			else if (CLK_EN)
				flg <= {cal > thr[0], cal < thr[1], cal > thr[2], cal < thr[3]};
		end

		assign alarm_v[9 - 2 * p]      = flg[3];
		assign alarm_v[8 - 2 * p]      = flg[2];
		assign warn_v[9 - 2 * p]       = flg[1];
		assign warn_v[8 - 2 * p]       = flg[0];
		assign live_b[2 * p]     = cal[15:8];
		assign live_b[2 * p + 1] = cal[7:0];
	end

	for (genvar s = 2 * mmsp_pkg::NUM_MON; s < 16; s++) begin : g_live
		if (s == mmsp_pkg::STAT_SLOT) begin : g_st
			assign live_b[s] = {tx_dis_s, soft_dis, 3'h0, TX_FAULT, RX_SIGNAL_LOST, 1'b0};
		end else begin : g_zero
			assign live_b[s] = 8'h00;
		end
	end

	for (genvar f = 0; f < 8; f++) begin : g_flag
		if (f == mmsp_pkg::ALM_SLOT) begin : g_a0
			assign flag_b[f] = alarm_v[9:2];
		end else if (f == mmsp_pkg::ALM_SLOT + 1) begin : g_a1
			assign flag_b[f] = {alarm_v[1:0], 6'h00};
		end else if (f == mmsp_pkg::WRN_SLOT) begin : g_w0
			assign flag_b[f] = warn_v[9:2];
		end else if (f == mmsp_pkg::WRN_SLOT + 1) begin : g_w1
			assign flag_b[f] = {warn_v[1:0], 6'h00};
		end else begin : g_fz
			assign flag_b[f] = 8'h00;
		end
	end

	// ----------------------------------------
	// Map view
	// ----------------------------------------
	// Live and flag bytes overlay storage; APB writes there are kept but hidden
	function automatic logic [7:0] view(input logic [8:0] idx);
		logic [7:0] b;
		b = mem[idx];
		if (idx[8] && idx[7:4] == mmsp_pkg::LIVE_HI)
			b = live_b[idx[3:0]];
		else if (idx[8] && idx[7:3] == mmsp_pkg::FLAG_HI)
			b = flag_b[idx[2:0]];
		return b;
	endfunction

	assign ser_view = view({ser_map, ser_ptr});

	wire logic [7:0]  apb_view = view(apb_idx);
	wire logic [31:0] status_w = {28'h000_0000, ser_busy, RX_SIGNAL_LOST, TX_FAULT, TX_OFF};
	wire logic [31:0] ctrl_w   = {30'h0000_0000, ctrl};
	wire logic [31:0] rd_sel   = mem_hit  ? {24'h00_0000, apb_view} :
	                             ctrl_hit ? ctrl_w :
	                             stat_hit ? status_w : 32'h0000_0000;

	// Read data is caught in the setup cycle so it comes from a flop
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			PRDATA <= 32'h0000_0000;
		else if (CLK_EN && setup && !PWRITE)
			PRDATA <= rd_sel;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_tx_off_time: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		$rose(TX_DISABLE) |-> ##[1:TxLim] TX_OFF)
		else $error("Transmitter not off in time");

	a_tx_held_off: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(TX_DISABLE && CLK_EN) [*4] |-> TX_OFF)
		else $error("Transmitter on while disabled");

	a_lost_level: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(RX_SIGNAL_DETECT == 1'b0 && CLK_EN) [*4] |-> RX_SIGNAL_LOST)
		else $error("Loss of signal not shown");

	a_fault_level: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(!LASER_FAULT && CLK_EN) [*4] |-> !TX_FAULT)
		else $error("Fault shown without a laser fault");

	a_presence_low: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		PRESENCE_PIN == 1'b0)
		else $error("Presence pin not grounded");

	a_prot_write: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		ser_wr.valid && !ser_allow && !apb_we |=>
		mem[$past(ser_idx)] == $past(mem[ser_idx]))
		else $error("Protected byte changed by serial write");

	a_temp_alarm: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		CLK_EN && g_mon[0].cal > g_mon[0].thr[0] |=> alarm_v[9] && flag_b[0][7])
		else $error("Temperature high alarm missing");

	a_live_read: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		CLK_EN && setup && !PWRITE && PADDR == 12'hd80 && !ext_cal |=>
		PRDATA[7:0] == $past(8'(({MON.temp} + g_mon[0].ofs) >> 8)))
		else $error("Live temperature not calibrated");

	c_serial_write: cover property (@(posedge CLOCK) disable iff (!RST_B) ser_we);
	c_prot_write: cover property (@(posedge CLOCK) disable iff (!RST_B) ser_wr.valid && !ser_allow);
	c_tx_off: cover property (@(posedge CLOCK) disable iff (!RST_B) $rose(TX_OFF));

endmodule

/* File: mgmt_host.sv */
/*
 Two-wire host model: makes the serial clock and drives data open drain.
 Assumes pull-ups on both lines and a 100 ns clock; a bit takes 8 cycles.
*/
`timescale 1ns/1ps
module mgmt_host (
	// Clock
	input  wire logic clk,
	// Serial line
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda
);
	logic drv = 1'b1;
	initial scl = 1'b1;
	// Pull-up wins unless a party pulls low
	assign sda = drv & ~sda_oe;

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves mid low phase, well clear of both clock edges
	task automatic bitx(input logic b, output logic r);
		wait_n(2);
		drv <= b;
		wait_n(3);
		scl <= 1'b1;
		wait_n(3);
		r = sda;
		scl <= 1'b0;
	endtask

	task automatic start;
		wait_n(4);
		drv <= 1'b1;
		wait_n(4);
		scl <= 1'b1;
		wait_n(4);
		drv <= 1'b0;
		wait_n(4);
		scl <= 1'b0;
	endtask

	task automatic stop;
		wait_n(2);
		drv <= 1'b0;
		wait_n(3);
		scl <= 1'b1;
		wait_n(4);
		drv <= 1'b1;
		wait_n(4);
	endtask

	task automatic byte_x(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(ai, ao);
	endtask
endmodule

/* File: test_module_mgmt_serial_port.sv */
/*
 Self-checking bench of the management port with a reference byte map.
 Assumes the package, design and host model are compiled first.
*/
`timescale 1ns/1ps
module test_module_mgmt_serial_port;
	localparam int LIM = 20;
	localparam logic [6:0] ID = mmsp_pkg::DEV_ID;
	localparam logic [6:0] DG = mmsp_pkg::DEV_DIAG;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic tx_dis = 1'b1;
	logic det = 1'b0;
	logic flt = 1'b0;
	mmsp_pkg::mon_t mon = '0;
	mmsp_pkg::mon_t m;
	logic [31:0] prdata, q;
	logic pready, pslverr, sda_oe, scl, sda, tx_off, lost, tx_fault, pres, ack, perr;
	logic sda_out;
	logic ce = 1'b1;
	logic [15:0] raw, off, sum;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 86;
	int mem [512];

	always #50 clock = ~clock;

	module_mgmt_serial_port #(.TX_OFF_LIMIT(LIM)) DUT (
		.CLOCK(clock), .RST_B(rst_b), .CLK_EN(ce),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.TX_DISABLE(tx_dis), .RX_SIGNAL_DETECT(det), .LASER_FAULT(flt), .MON(mon),
		.TX_OFF(tx_off), .RX_SIGNAL_LOST(lost), .TX_FAULT(tx_fault), .PRESENCE_PIN(pres));

	mgmt_host HOST (.clk(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	task automatic final_report;
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// A hung handshake must still end the run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			final_report;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input int a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 12'(a);
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the slave
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic mw(input int i, input logic [31:0] d);
		apb(1'b1, 'h800 + 4 * i, d);
		mem[i] = d[7:0];
	endtask

	task automatic mr(input int i);
		apb(1'b0, 'h800 + 4 * i, 0);
		chk(q, mem[i]);
	endtask

	task automatic sw(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d);
		logic [7:0] r;
		HOST.start;
		HOST.byte_x({dev, 1'b0}, 1'b1, r, ack);
		HOST.byte_x(p, 1'b1, r, ack);
		HOST.byte_x(d, 1'b1, r, ack);
		chk(ack, 0);
		HOST.stop;
		if (dev == DG && p >= 8'h80)
			mem[256 + p] = d;
	endtask

	task automatic sr(input logic [6:0] dev, input logic [7:0] p, input int n);
		logic [7:0] r;
		HOST.start;
		HOST.byte_x({dev, 1'b0}, 1'b1, r, ack);
		chk(ack, 0);
		HOST.byte_x(p, 1'b1, r, ack);
		HOST.start;
		HOST.byte_x({dev, 1'b1}, 1'b1, r, ack);
		for (int i = 0; i < n; i++) begin
			HOST.byte_x(8'hff, i == n - 1, r, ack);
			chk(r, mem[(dev == DG) * 256 + 8'(p + i)]);
		end
		HOST.stop;
	endtask

	initial begin
		for (int i = 0; i < 512; i++)
			mem[i] = 0;
		repeat (12) @(posedge clock);
		chk(tx_off, 1);
		rst_b <= 1'b1;
		repeat (6) @(posedge clock);
		chk(pres, 0);
		for (int i = 0; i < 8; i++) begin
			tx_dis <= i[0];
			det <= i[1];
			flt <= i[2];
			repeat (LIM) @(posedge clock);
			chk(tx_off, i[0]);
			chk(lost, !i[1]);
			chk(tx_fault, i[2]);
		end
		// Enable low must freeze the pin pipeline
		ce <= 1'b0;
		tx_dis <= 1'b0;
		repeat (6) @(posedge clock);
		chk(tx_off, 1);
		ce <= 1'b1;
		repeat (6) @(posedge clock);
		chk(tx_off, 0);
		foreach (mem[i])
			if (i % 64 < 3 || i % 256 > 252)
				mw(i, $random(seed));
		sr(ID, 8'hfe, 4);
		sr(DG, 8'hfd, 5);
		sr(ID, 8'h40, 1);
		sw(ID, 8'h01, 8'h5a);
		sw(DG, 8'h02, 8'ha5);
		sw(DG, 8'hfe, 8'($random(seed)));
		mr(1);
		mr(258);
		mr(510);
		HOST.start;
		HOST.byte_x({7'h52, 1'b0}, 1'b1, q[7:0], ack);
		HOST.stop;
		chk(ack, 1);
		apb(1'b0, 'h008, 0);
		chk({perr, q}, {1'b1, 32'h0000_0000});
		m = {$random(seed), $random(seed), 16'($random(seed))};
		raw = 16'h8000 + 16'($random(seed) & 'h3fff);
		off = 16'($random(seed));
		// Internal calibration adds the offset with a 16-bit wrap
		sum = raw + off;
		m.temp = raw;
		mon <= m;
		mw(336, off[15:8]);
		mw(337, off[7:0]);
		mem[352] = sum[15:8];
		mem[353] = sum[7:0];
		sr(DG, 8'd96, 2);
		apb(1'b0, 'hd80, 0);
		chk(q, mem[352]);
		apb(1'b1, 'h000, 1);
		mem[352] = raw[15:8];
		mem[353] = raw[7:0];
		sr(DG, 8'd96, 2);
		mw(256, raw[15:8]);
		mw(257, raw[7:0] - 8'h01);
		if (raw[7:0] == 8'h00)
			mw(256, raw[15:8] - 8'h01);
		apb(1'b0, 'h800 + 4 * 368, 0);
		chk(q & 32'h80, 32'h80);
		mw(256, 8'hff);
		mw(257, 8'hff);
		apb(1'b0, 'h800 + 4 * 368, 0);
		chk(q & 32'h80, 0);
		// Soft disable alone must turn the transmitter off
		apb(1'b1, 'h000, 2);
		repeat (4) @(posedge clock);
		chk(tx_off, 1);
		apb(1'b0, 'h004, 0);
		chk(q, 32'h0000_0003);
		chk(sda_out, 0);
		final_report;
	end
endmodule
